// ==== verilog/splr_defines.vh ====
// Register map, reset values and timing counts of the set point limiter and ramp.
// Values are signed tenths of a unit; included by splr_top.v.
`ifndef SPLR_DEFINES_VH
`define SPLR_DEFINES_VH

// Register byte offsets
`define SPLR_REG_CTRL      8'h00
`define SPLR_REG_TARGET_SP 8'h04
`define SPLR_REG_UPPER     8'h08
`define SPLR_REG_LOWER     8'h0c
`define SPLR_REG_RISE      8'h10
`define SPLR_REG_FALL      8'h14
`define SPLR_REG_PV        8'h18
`define SPLR_REG_REMOTE_SP 8'h1c
`define SPLR_REG_RANGE_HI  8'h20
`define SPLR_REG_RANGE_LO  8'h24
`define SPLR_REG_RAMP_SP   8'h28
`define SPLR_REG_EFF_SP    8'h2c
`define SPLR_REG_ALARM_SP  8'h30
`define SPLR_REG_STATUS    8'h34
`define SPLR_REG_CMD       8'h38

// Control register fields
`define SPLR_CTRL_RUN      0
`define SPLR_CTRL_REMOTE   1
`define SPLR_CTRL_ALSEL    2
`define SPLR_CTRL_ERROR    3
`define SPLR_CTRL_UNIT     4
`define SPLR_CTRL_BANK_LO  8
`define SPLR_CTRL_DBANK_LO 12

// Command register fields (write one to act)
`define SPLR_CMD_LIM_RESET 0
`define SPLR_CMD_RANGE_CHG 1
`define SPLR_CMD_AT_REQ    2
`define SPLR_CMD_AT_CANCEL 3

// Status register fields
`define SPLR_ST_RAMPING    0
`define SPLR_ST_AT_PEND    1
`define SPLR_ST_AT_RUN     2
`define SPLR_ST_RISING     3

// Reset values, tenths of a degree
`define SPLR_UPPER_RESET   32'sd13000
`define SPLR_LOWER_RESET   -32'sd2000
`define SPLR_RAMP_OFF      16'h0000

// Ramp time units: 1 s or 60 s per step, in ms
`define SPLR_STEP_SEC_MS   32'h0000_03e8
`define SPLR_STEP_MIN_MS   32'h0000_ea60
`define SPLR_CLK_KHZ       32'h0000_c350

`endif

// ==== verilog/splr_top.v ====
// Set point limiter and ramp generator with an AXI4-Lite register slave.
// Assumes one 50 MHz clock and that the process value is written by software.
`timescale 1ns/1ns
`default_nettype none
`include "splr_defines.vh"

// Behaviour
// - Target set point clamped to bounds
// - Upper bound defaults to 1300.0
// - Lower bound defaults to -200.0
// - Bound change pulls set point inside
// - Limiter reset forces set point to bound
// - Range change resets bounds to range
// - Regulate to rate-limited intermediate set point
// - Ramp value zero means ramp off
// - Ramp values stored per bank
// - Intermediate ramp set point readable
// - Adjustment write goes to active bank
// - Ramp continues across local/remote switch
// - Start ramp from process value
// - Direction from ramp set point versus clamped target
// - Auto-tuning deferred until ramp ends
// - Ramp disabled when stopped or error
// - Alarm reference selects ramp or target
module splr_top #(
  parameter         BANKS    = 8,
  parameter         BANK_W   = 3,
  // Cycles per ramp step; unsigned, since the minute count overflows an integer
  parameter [31:0]  STEP_SEC = `SPLR_STEP_SEC_MS * `SPLR_CLK_KHZ,
  parameter [31:0]  STEP_MIN = `SPLR_STEP_MIN_MS * `SPLR_CLK_KHZ
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] effective_sp,
  output reg  [31:0] alarm_sp,
  output wire        ramping,
  output reg         autotune_run
);

  // Stored configuration
  reg        [31:0]   ctrl;
  reg signed [31:0]   target_sp;
  reg signed [31:0]   sp_upper_bound;
  reg signed [31:0]   sp_lower_bound;
  reg signed [31:0]   proc_value;
  reg signed [31:0]   remote_sp;
  reg signed [31:0]   range_hi;
  reg signed [31:0]   range_lo;
  reg        [15:0]   ramp_rise_value [0:BANKS-1];
  reg        [15:0]   ramp_fall_value [0:BANKS-1];
  reg signed [31:0]   ramp_sp;
  reg                 prev_run;
  reg                 started;
  reg                 at_pend;
  reg        [31:0]   step_cnt;

  // Write channel holding registers
  reg                 aw_held;
  reg                 w_held;
  reg        [7:0]    aw_addr;
  reg        [31:0]   w_data;
  reg        [3:0]    w_strb;

  wire                run_mode = ctrl[`SPLR_CTRL_RUN];
  wire                ramp_time_unit = ctrl[`SPLR_CTRL_UNIT];
  wire       [BANK_W-1:0] act_bank  = ctrl[`SPLR_CTRL_BANK_LO +: BANK_W];
  wire       [BANK_W-1:0] disp_bank = ctrl[`SPLR_CTRL_DBANK_LO +: BANK_W];
  wire       [15:0]   rise_now = ramp_rise_value[act_bank];
  wire       [15:0]   fall_now = ramp_fall_value[act_bank];

  // Source of the final set point: local or remote, always clamped
  wire signed [31:0]  raw_sp = ctrl[`SPLR_CTRL_REMOTE] ? remote_sp : target_sp;
  wire signed [31:0]  final_sp = (raw_sp > sp_upper_bound) ? sp_upper_bound :
                                 (raw_sp < sp_lower_bound) ? sp_lower_bound : raw_sp;

  wire                rising = ramp_sp < final_sp;
  // fall value for decreases, falling back to rise value when off
  wire       [15:0]   rate = rising ? rise_now : ((fall_now != `SPLR_RAMP_OFF) ? fall_now : rise_now);
  // zero rise value disables ramp; stop or error disables too
  wire                ramp_en = (rise_now != `SPLR_RAMP_OFF) && run_mode && !ctrl[`SPLR_CTRL_ERROR];
  assign ramping = ramp_en && (ramp_sp != final_sp);

  wire       [31:0]   step_len = ramp_time_unit ? STEP_MIN : STEP_SEC;
  wire                step_tick = (step_cnt >= step_len - 32'h0000_0001);

  // Bus handshakes: accept address and data separately, answer once both are in
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire                do_write = aw_held && w_held && !s_axi_bvalid;
  wire       [7:0]    wr_addr  = aw_addr;
  wire       [31:0]   wr_mask  = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [31:0] mask;
    begin
      merge = (old & ~mask) | (data & mask);
    end
  endfunction

  function wr_ok;
    input [7:0] addr;
    begin
      wr_ok = (addr <= `SPLR_REG_REMOTE_SP) || (addr == `SPLR_REG_RANGE_HI) ||
              (addr == `SPLR_REG_RANGE_LO) || (addr == `SPLR_REG_CMD);
    end
  endfunction

  wire                cmd_wr   = do_write && (wr_addr == `SPLR_REG_CMD);
  wire                lim_rst  = cmd_wr && w_strb[0] && w_data[`SPLR_CMD_LIM_RESET];
  wire                rng_chg  = cmd_wr && w_strb[0] && w_data[`SPLR_CMD_RANGE_CHG];
  wire                at_req   = cmd_wr && w_strb[0] && w_data[`SPLR_CMD_AT_REQ];
  wire                at_cncl  = cmd_wr && w_strb[0] && w_data[`SPLR_CMD_AT_CANCEL];

  // Write address and data capture, write response
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Unmapped or read-only offsets answer SLVERR
        s_axi_bresp  <= (wr_ok(wr_addr) && wr_addr[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers and limiter
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl           <= 32'h0000_0000;
      target_sp      <= 32'h0000_0000;
      sp_upper_bound <= `SPLR_UPPER_RESET;
      sp_lower_bound <= `SPLR_LOWER_RESET;
      proc_value     <= 32'h0000_0000;
      remote_sp      <= 32'h0000_0000;
      range_hi       <= `SPLR_UPPER_RESET;
      range_lo       <= `SPLR_LOWER_RESET;
    end else begin
      if (do_write) begin
        case (wr_addr)
          `SPLR_REG_CTRL:      ctrl           <= merge(ctrl, w_data, wr_mask);
          `SPLR_REG_TARGET_SP: target_sp      <= merge(target_sp, w_data, wr_mask);
          `SPLR_REG_UPPER:     sp_upper_bound <= merge(sp_upper_bound, w_data, wr_mask);
          `SPLR_REG_LOWER:     sp_lower_bound <= merge(sp_lower_bound, w_data, wr_mask);
          `SPLR_REG_PV:        proc_value     <= merge(proc_value, w_data, wr_mask);
          `SPLR_REG_REMOTE_SP: remote_sp      <= merge(remote_sp, w_data, wr_mask);
          `SPLR_REG_RANGE_HI:  range_hi       <= merge(range_hi, w_data, wr_mask);
          `SPLR_REG_RANGE_LO:  range_lo       <= merge(range_lo, w_data, wr_mask);
          default: begin
          end
        endcase
      end
      // Not in a write cycle, so a fresh write is never overridden
      // pull stored set point inside after bound change
      if (!do_write && target_sp > sp_upper_bound)
        target_sp <= sp_upper_bound;
      else if (!do_write && target_sp < sp_lower_bound)
        target_sp <= sp_lower_bound;
      if (lim_rst) begin
        if (target_sp > sp_upper_bound)
          target_sp <= sp_upper_bound;
        else if (target_sp < sp_lower_bound)
          target_sp <= sp_lower_bound;
      end
      if (rng_chg) begin
        sp_upper_bound <= range_hi;
        sp_lower_bound <= range_lo;
      end
    end
  end

  // Byte-merged write value; only the low half is stored, upper bytes dropped
  wire       [31:0]   rise_merged  = merge({16'h0000, rise_now}, w_data, wr_mask);
  wire       [31:0]   fall_merged  = merge({16'h0000, fall_now}, w_data, wr_mask);
  wire       [31:0]   act_bank_ext = {{(32-BANK_W){1'b0}}, act_bank};

  // Per-bank ramp values; the adjustment path writes the active bank
  genvar gi;
  generate
    for (gi = 0; gi < BANKS; gi = gi + 1) begin : g_bank
      always @(posedge aclk) begin
        if (!aresetn) begin
          ramp_rise_value[gi] <= `SPLR_RAMP_OFF;
          ramp_fall_value[gi] <= `SPLR_RAMP_OFF;
        end else if (do_write && (wr_addr == `SPLR_REG_RISE)) begin
          if (act_bank_ext == gi)
            ramp_rise_value[gi] <= rise_merged[15:0];
        end else if (do_write && (wr_addr == `SPLR_REG_FALL)) begin
          if (act_bank_ext == gi)
            ramp_fall_value[gi] <= fall_merged[15:0];
        end
      end
    end
  endgenerate

  // Ramp generator: one step of rate every time unit
  always @(posedge aclk) begin
    if (!aresetn) begin
      ramp_sp  <= 32'h0000_0000;
      prev_run <= 1'b0;
      started  <= 1'b0;
      step_cnt <= 32'h0000_0000;
    end else begin
      prev_run <= run_mode;
      started  <= 1'b1;
      // Counter idles at zero, so every new ramp waits one full step
      step_cnt <= (step_tick || !ramping) ? 32'h0000_0000 : step_cnt + 32'h0000_0001;
      if ((!started || (run_mode && !prev_run)) && ramp_en) begin
        ramp_sp <= proc_value;
      end else if (!ramp_en) begin
        // ramp bypassed, track final set point
        ramp_sp <= final_sp;
      end else if (step_tick && ramping) begin
        // advance toward whichever source is selected
        if (rising)
          ramp_sp <= (final_sp - ramp_sp > $signed({16'h0000, rate})) ? ramp_sp + $signed({16'h0000, rate}) : final_sp;
        else
          ramp_sp <= (ramp_sp - final_sp > $signed({16'h0000, rate})) ? ramp_sp - $signed({16'h0000, rate}) : final_sp;
      end
    end
  end

  // Auto-tuning request held off while ramping
  always @(posedge aclk) begin
    if (!aresetn) begin
      at_pend      <= 1'b0;
      autotune_run <= 1'b0;
    end else begin
      // Cancel wins over a request in the same command
      if (at_cncl) begin
        at_pend      <= 1'b0;
        autotune_run <= 1'b0;
      end else if ((at_req || at_pend) && !ramping && run_mode) begin
        at_pend      <= 1'b0;
        autotune_run <= 1'b1;
      end else if (at_req) begin
        at_pend <= 1'b1;
      end
    end
  end

  // Outputs toward the control loop and alarms
  always @(posedge aclk) begin
    if (!aresetn) begin
      effective_sp <= 32'h0000_0000;
      alarm_sp     <= 32'h0000_0000;
    end else begin
      effective_sp <= ramp_sp;
      alarm_sp     <= ctrl[`SPLR_CTRL_ALSEL] ? final_sp : ramp_sp;
    end
  end

  // Read channel: one-cycle answer after address taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (s_axi_araddr)
        `SPLR_REG_CTRL:      s_axi_rdata <= ctrl;
        `SPLR_REG_TARGET_SP: s_axi_rdata <= target_sp;
        `SPLR_REG_UPPER:     s_axi_rdata <= sp_upper_bound;
        `SPLR_REG_LOWER:     s_axi_rdata <= sp_lower_bound;
        `SPLR_REG_RISE:      s_axi_rdata <= {16'h0000, ramp_rise_value[disp_bank]};
        `SPLR_REG_FALL:      s_axi_rdata <= {16'h0000, ramp_fall_value[disp_bank]};
        `SPLR_REG_PV:        s_axi_rdata <= proc_value;
        `SPLR_REG_REMOTE_SP: s_axi_rdata <= remote_sp;
        `SPLR_REG_RANGE_HI:  s_axi_rdata <= range_hi;
        `SPLR_REG_RANGE_LO:  s_axi_rdata <= range_lo;
        `SPLR_REG_RAMP_SP:   s_axi_rdata <= ramp_sp;
        `SPLR_REG_EFF_SP:    s_axi_rdata <= final_sp;
        `SPLR_REG_ALARM_SP:  s_axi_rdata <= alarm_sp;
        `SPLR_REG_STATUS:    s_axi_rdata <= {28'h0000000, rising, autotune_run, at_pend, ramping};
        // Command bits are strobes and read back as zero
        `SPLR_REG_CMD:       s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // splr_top
`default_nettype wire

// ==== verif/splr_sva.sv ====
// Concurrent checks on the bus handshake and ramp outputs of splr_top.
// Assumes it is bound to splr_top and that everything runs on aclk.
`timescale 1ns/1ns
`default_nettype none
module splr_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] effective_sp,
  input wire logic        ramping,
  input wire logic        autotune_run
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address and data taken at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  // A ramp step landed while the ramp goes on
  sequence ramp_step;
    (ramping && $changed(effective_sp)) ##1 ramping;
  endsequence

  bresp_follow_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rvalid_follow_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during data");
  at_defer_a: assert property ($rose(autotune_run) |-> !ramping)
    else $error("tuning started while ramping");
  ramp_pace_a: assert property (ramp_step |-> $stable(effective_sp))
    else $error("ramp stepped too fast");
endmodule // splr_sva

bind splr_top splr_sva u_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .effective_sp(effective_sp),
  .ramping(ramping), .autotune_run(autotune_run)
);
`default_nettype wire

// ==== verif/splr_plant_model.sv ====
// Thermal plant behind the controller: its process value lags the set point.
// Assumes the bench copies pv into the process value register.
`timescale 1ns/1ns
`default_nettype none
module splr_plant_model #(
  parameter integer START = 40
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] effective_sp,
  output var  logic [31:0] pv
);
  // One tenth per cycle toward the set point, a fixed-rate slew
  always @(posedge aclk) begin
    if (!aresetn)
      pv <= START;
    else if ($signed(pv) < $signed(effective_sp))
      pv <= pv + 32'h1;
    else if ($signed(pv) > $signed(effective_sp))
      pv <= pv - 32'h1;
  end
endmodule // splr_plant_model
`default_nettype wire

// ==== verif/tb_setpoint_limiter_ramp.sv ====
// Self-checking bench for splr_top, driven over AXI4-Lite.
// Assumes short step counts: 4 cycles per second step, 8 per minute step.
`timescale 1ns/1ns
`default_nettype none
`include "splr_defines.vh"
module tb_setpoint_limiter_ramp;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, p, v;
  logic [1:0]  resp;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata, eff, alarm_sp, pv;
  wire         awready, wready, bvalid, arready, rvalid, ramping, autotune_run;
  int          fails, checks, n;

  splr_top #(.STEP_SEC(4), .STEP_MIN(8)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .effective_sp(eff),
    .alarm_sp(alarm_sp), .ramping(ramping), .autotune_run(autotune_run));
  splr_plant_model plant (.aclk(aclk), .aresetn(aresetn), .effective_sp(eff), .pv(pv));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Both channels held until taken; ready follows valid so a held answer is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    logic done;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      done = bvalid === 1'b1 && bready === 1'b1;
      bready <= !done && bvalid === 1'b1;
      k++;
    end while (!done && k < 50);
    resp = bresp;
    if (k >= 50) fails++;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int k = 0;
    logic done;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      done = rvalid === 1'b1 && rready === 1'b1;
      rready <= !done && rvalid === 1'b1;
      k++;
    end while (!done && k < 50);
    d = rdata;
    resp = rresp;
    if (k >= 50) fails++;
    @(posedge aclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    logic [31:0] d;
    rd(a, d);
    check(d & m, e);
  endtask

  // Bounded wait for the ramp to settle on its target
  task automatic wait_idle(output int c);
    c = 0;
    while (ramping !== 1'b0 && c < 400) begin
      @(posedge aclk);
      c++;
    end
    if (c >= 400) fails++;
  endtask

  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Free-running 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Whole run is under a thousand cycles; this leaves wide margin
  initial begin
    #100000;
    fails++;
    print_verdict;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(`SPLR_REG_UPPER, 32'h32c8);
    rdc(`SPLR_REG_LOWER, 32'hfffff830);
    rdc(`SPLR_REG_RISE, 32'h0);
    rdc(8'h3c, 32'h0);
    check(resp, 32'h2);
    wr(`SPLR_REG_RAMP_SP, 32'h1);
    check(resp, 32'h2);
    // Rising ramp from the plant's value, with a deferred tuning request
    wr(`SPLR_REG_TARGET_SP, 32'hc8);
    rdc(`SPLR_REG_RAMP_SP, 32'hc8);
    p = pv;
    wr(`SPLR_REG_PV, p);
    wr(`SPLR_REG_RISE, 32'ha);
    wr(`SPLR_REG_CTRL, 32'h1);
    check(ramping, 32'h1);
    rdc(`SPLR_REG_STATUS, 32'h9, 32'h9);
    rd(`SPLR_REG_RAMP_SP, v);
    check($signed(v) >= $signed(p) && $signed(v) <= $signed(p) + 20, 32'h1);
    wr(`SPLR_REG_CMD, 32'h4);
    rdc(`SPLR_REG_STATUS, 32'h2, 32'h6);
    wr(`SPLR_REG_CTRL, 32'h5);
    check(alarm_sp, 32'hc8);
    wr(`SPLR_REG_CTRL, 32'h1);
    check($signed(alarm_sp) < 200, 32'h1);
    wait_idle(n);
    check(n > 20, 32'h1);
    rdc(`SPLR_REG_RAMP_SP, 32'hc8);
    check(eff, 32'hc8);
    check(autotune_run, 32'h1);
    wr(`SPLR_REG_CMD, 32'h8);
    check(autotune_run, 32'h0);
    // Per-bank rates: active bank in [10:8], display bank in [14:12]
    wr(`SPLR_REG_CTRL, 32'h1101);
    rdc(`SPLR_REG_RISE, 32'h0);
    wr(`SPLR_REG_RISE, 32'h1e);
    wr(`SPLR_REG_CTRL, 32'h0101);
    rdc(`SPLR_REG_RISE, 32'ha);
    wr(`SPLR_REG_CTRL, 32'h1001);
    rdc(`SPLR_REG_RISE, 32'h1e);
    wr(`SPLR_REG_CTRL, 32'h0201);
    wr(`SPLR_REG_TARGET_SP, 32'h64);
    check(ramping, 32'h0);
    rdc(`SPLR_REG_RAMP_SP, 32'h64);
    // Falling ramp in minute steps
    wr(`SPLR_REG_CTRL, 32'h0011);
    wr(`SPLR_REG_FALL, 32'h32);
    wr(`SPLR_REG_TARGET_SP, 32'hffffff9c);
    rdc(`SPLR_REG_STATUS, 32'h1, 32'h9);
    wait_idle(n);
    check(n > 20 && n < 40, 32'h1);
    // Remote source keeps the ramp; stop and error kill it
    wr(`SPLR_REG_REMOTE_SP, 32'h64);
    wr(`SPLR_REG_CTRL, 32'h0013);
    check(ramping, 32'h1);
    wait_idle(n);
    check(n > 100, 32'h1);
    rdc(`SPLR_REG_RAMP_SP, 32'h64);
    wr(`SPLR_REG_REMOTE_SP, 32'hffffff9c);
    wr(`SPLR_REG_CTRL, 32'h001b);
    check(ramping, 32'h0);
    rdc(`SPLR_REG_RAMP_SP, 32'hffffff9c);
    wr(`SPLR_REG_CTRL, 32'h0013);
    wr(`SPLR_REG_REMOTE_SP, 32'h64);
    check(ramping, 32'h1);
    wr(`SPLR_REG_CTRL, 32'h0012);
    check(ramping, 32'h0);
    // Limiter bounds, clamping and range change
    wr(`SPLR_REG_CTRL, 32'h0);
    wr(`SPLR_REG_TARGET_SP, 32'h4e20);
    rdc(`SPLR_REG_EFF_SP, 32'h32c8);
    wr(`SPLR_REG_TARGET_SP, 32'hffffec78);
    rdc(`SPLR_REG_EFF_SP, 32'hfffff830);
    wr(`SPLR_REG_TARGET_SP, 32'h1388);
    wr(`SPLR_REG_UPPER, 32'hbb8);
    rdc(`SPLR_REG_EFF_SP, 32'hbb8);
    wr(`SPLR_REG_CMD, 32'h1);
    rdc(`SPLR_REG_TARGET_SP, 32'hbb8);
    wr(`SPLR_REG_RANGE_HI, 32'h32c8);
    wr(`SPLR_REG_RANGE_LO, 32'hfffff830);
    wr(`SPLR_REG_LOWER, 32'h0);
    wr(`SPLR_REG_CMD, 32'h2);
    rdc(`SPLR_REG_UPPER, 32'h32c8);
    rdc(`SPLR_REG_LOWER, 32'hfffff830);
    print_verdict;
  end
endmodule // tb_setpoint_limiter_ramp
`default_nettype wire
